/* File: design/smx_speaker_mixer_top.sv */
// Speaker mixer routing control: register bank on classic Wishbone and
// two mixer channels. Assumes sources are samples on clk_i with one strobe.
//
// Function
// - Each mixer sums any combination of its six enabled sources.
// - Volume register bit 8 mutes its mixer; resets to 1, write 0 unmutes.
// - Select bit 7 feeds gain stage from mixer (1) or same-side converter (0).
// - Select bits 5 and 4 enable left and right converter paths; reset 0.
// - Shared attenuation register gives each converter path optional -6dB; reset 0.
// - Select bits 3 and 2 enable left and right input-mixer paths; reset 0.
// - Volume bits 7 and 6 give input-mixer paths -6dB when set; reset 0.
// - Select bits 1 and 0 enable left and right bypass pin paths; reset 0.
// - Bypass gains at 5:3 and 2:0, -15dB to +6dB in 3dB steps; reset 111.
// - Enable register bits 1 and 0 power left and right mixers; reset 0.
`timescale 1ns/1ps
module smx_speaker_mixer_top
  import smx_pkg::*;
(
  // System
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic        [9:0]  wb_adr_i,
  input  wire logic        [3:0]  wb_sel_i,
  input  wire logic        [31:0] wb_dat_i,
  output logic             [31:0] wb_dat_o,
  output logic                    wb_ack_o,
  // Audio sources
  input  wire logic               sample_valid_i,
  input  wire logic signed [15:0] left_converter_out_i,
  input  wire logic signed [15:0] right_converter_out_i,
  input  wire logic signed [15:0] left_input_mixer_i,
  input  wire logic signed [15:0] right_input_mixer_i,
  input  wire logic signed [15:0] left_bypass_pin_i,
  input  wire logic signed [15:0] right_bypass_pin_i,
  // Audio results
  output logic signed      [15:0] left_out_mixer_o,
  output logic signed      [15:0] right_out_mixer_o,
  output logic signed      [15:0] left_gain_stage_o,
  output logic signed      [15:0] right_gain_stage_o,
  output logic                    sample_valid_o,
  // Analogue controls
  output logic                    left_out_mixer_power_en_o,
  output logic                    right_out_mixer_power_en_o,
  output logic                    left_gain_stage_source_sel_o,
  output logic                    right_gain_stage_source_sel_o
);

  smx_regs_s               s_q;
  smx_regs_s               s_d;
  logic                    req;
  logic                    wr;
  logic              [7:0] idx;
  logic              [8:0] lane;
  logic             [31:0] rd_val;
  logic              [1:0] clip_ev;
  logic              [1:0] vld;
  logic signed [1:0][15:0] mix;
  logic signed [1:0][15:0] stage;
  logic              [1:0] pwr;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Ack is registered, so a new request is seen only when ack is low
  assign req  = wb_cyc_i & wb_stb_i & ~s_q.ack;
  assign wr   = req & wb_we_i;
  assign idx  = wb_adr_i[9:2];
  assign lane = {wb_sel_i[1], {8{wb_sel_i[0]}}};

  function automatic logic [8:0] merge(input logic [8:0] old, input logic [8:0] mask,
                                       input logic [8:0] ln, input logic [8:0] dat);
    logic [8:0] m;
    m = mask & ln;
    return (old & ~m) | (dat & m);
  endfunction

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = '0;
    case (idx)
      SMX_IDX_MIX_EN:  rd_val[8:0] = s_q.mix_en & SMX_EN_MASK;
      SMX_IDX_SEL_L:   rd_val[8:0] = s_q.sel[0] & SMX_SEL_MASK;
      SMX_IDX_SEL_R:   rd_val[8:0] = s_q.sel[1] & SMX_SEL_MASK;
      SMX_IDX_VOL_L:   rd_val[8:0] = s_q.vol[0] & SMX_VOL_MASK;
      SMX_IDX_VOL_R:   rd_val[8:0] = s_q.vol[1] & SMX_VOL_MASK;
      SMX_IDX_DAC_ATT: rd_val[8:0] = s_q.dac_att & SMX_ATT_MASK;
      SMX_IDX_STATUS:  rd_val[3:0] = {~s_q.vol[0][SMX_VOL_MUTE_BIT] & pwr[0],
                                      ~s_q.vol[1][SMX_VOL_MUTE_BIT] & pwr[1],
                                      s_q.clip};
      default:         rd_val = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  always_comb begin
    s_d     = s_q;
    s_d.ack = req;
    if (req) begin
      s_d.rdat = rd_val;
    end
    if (wr) begin
      case (idx)
        SMX_IDX_MIX_EN: begin
          s_d.mix_en = merge(s_q.mix_en, SMX_EN_MASK, lane, wb_dat_i[8:0]);
        end
        SMX_IDX_SEL_L: begin
          s_d.sel[0] = merge(s_q.sel[0], SMX_SEL_MASK, lane, wb_dat_i[8:0]);
        end
        SMX_IDX_SEL_R: begin
          s_d.sel[1] = merge(s_q.sel[1], SMX_SEL_MASK, lane, wb_dat_i[8:0]);
        end
        SMX_IDX_VOL_L: begin
          s_d.vol[0] = merge(s_q.vol[0], SMX_VOL_MASK, lane, wb_dat_i[8:0]);
        end
        SMX_IDX_VOL_R: begin
          s_d.vol[1] = merge(s_q.vol[1], SMX_VOL_MASK, lane, wb_dat_i[8:0]);
        end
        SMX_IDX_DAC_ATT: begin
          s_d.dac_att = merge(s_q.dac_att, SMX_ATT_MASK, lane, wb_dat_i[8:0]);
        end
        SMX_IDX_STATUS: begin
          // Write one to clear a clip flag
          if (wb_sel_i[0]) begin
            s_d.clip = s_q.clip & ~wb_dat_i[1:0];
          end
        end
        default: begin
          s_d.clip = s_d.clip;
        end
      endcase
    end
    // A clip in the clearing cycle still sets the flag
    s_d.clip = s_d.clip | clip_ev;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q         <= '0;
      s_q.sel     <= {SMX_SEL_RST, SMX_SEL_RST};
      s_q.vol     <= {SMX_VOL_RST, SMX_VOL_RST};
      s_q.dac_att <= SMX_ATT_RST;
      s_q.mix_en  <= SMX_EN_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Mixer channels, index 0 left and 1 right
  // ----------------------------------------------------------------
  assign pwr[0] = s_q.mix_en[SMX_EN_LEFT_BIT];
  assign pwr[1] = s_q.mix_en[SMX_EN_RIGHT_BIT];

  for (genvar g = 0; g < 2; g++) begin : g_chan
    localparam int unsigned ATT_LSB = (g == 0) ? SMX_ATT_LEFT_LSB : SMX_ATT_RIGHT_LSB;
    smx_mix_chan u_chan (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .vld_i      (sample_valid_i),
      .ldac_i     (left_converter_out_i),
      .rdac_i     (right_converter_out_i),
      .lmix_i     (left_input_mixer_i),
      .rmix_i     (right_input_mixer_i),
      .lpin_i     (left_bypass_pin_i),
      .rpin_i     (right_bypass_pin_i),
      .direct_i   ((g == 0) ? left_converter_out_i : right_converter_out_i),
      .sel_i      (s_q.sel[g]),
      .vol_i      (s_q.vol[g]),
      .dac_att_i  (s_q.dac_att[ATT_LSB +: 2]),
      .power_en_i (pwr[g]),
      .mix_o      (mix[g]),
      .stage_o    (stage[g]),
      .vld_o      (vld[g]),
      .clip_o     (clip_ev[1 - g])
    );
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_ack_o                      = s_q.ack;
  assign wb_dat_o                      = s_q.rdat;
  assign left_out_mixer_o              = mix[0];
  assign right_out_mixer_o             = mix[1];
  assign left_gain_stage_o             = stage[0];
  assign right_gain_stage_o            = stage[1];
  assign sample_valid_o                = vld[0];
  assign left_out_mixer_power_en_o     = pwr[0];
  assign right_out_mixer_power_en_o    = pwr[1];
  assign left_gain_stage_source_sel_o  = s_q.sel[0][SMX_SEL_SRC_BIT];
  assign right_gain_stage_source_sel_o = s_q.sel[1][SMX_SEL_SRC_BIT];

endmodule

/* File: design/smx_pkg.sv */
// Constants, register map and state types for the speaker mixer control.
// Assumes one 40 MHz clock and a synchronous active-high reset.
package smx_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned SMX_DW  = 16;
  localparam int unsigned SMX_RW  = 9;
  localparam int unsigned SMX_SUM = 20;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] SMX_IDX_MIX_EN  = 8'h63;
  localparam logic [7:0] SMX_IDX_SEL_L   = 8'h69;
  localparam logic [7:0] SMX_IDX_SEL_R   = 8'h6a;
  localparam logic [7:0] SMX_IDX_VOL_L   = 8'h6b;
  localparam logic [7:0] SMX_IDX_VOL_R   = 8'h6c;
  localparam logic [7:0] SMX_IDX_DAC_ATT = 8'h6d;
  localparam logic [7:0] SMX_IDX_STATUS  = 8'h7f;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned SMX_SEL_SRC_BIT   = 7;
  localparam int unsigned SMX_SEL_LDAC_BIT  = 5;
  localparam int unsigned SMX_SEL_RDAC_BIT  = 4;
  localparam int unsigned SMX_SEL_LMIX_BIT  = 3;
  localparam int unsigned SMX_SEL_RMIX_BIT  = 2;
  localparam int unsigned SMX_SEL_LPIN_BIT  = 1;
  localparam int unsigned SMX_SEL_RPIN_BIT  = 0;
  localparam int unsigned SMX_VOL_MUTE_BIT  = 8;
  localparam int unsigned SMX_VOL_LMIX_BIT  = 7;
  localparam int unsigned SMX_VOL_RMIX_BIT  = 6;
  localparam int unsigned SMX_VOL_LPIN_LSB  = 3;
  localparam int unsigned SMX_VOL_RPIN_LSB  = 0;
  localparam int unsigned SMX_ATT_LEFT_LSB  = 6;
  localparam int unsigned SMX_ATT_RIGHT_LSB = 4;
  localparam int unsigned SMX_EN_LEFT_BIT   = 1;
  localparam int unsigned SMX_EN_RIGHT_BIT  = 0;

  // ----------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [8:0] SMX_SEL_RST  = 9'h000;
  localparam logic [8:0] SMX_VOL_RST  = 9'h13f;
  localparam logic [8:0] SMX_ATT_RST  = 9'h000;
  localparam logic [8:0] SMX_EN_RST   = 9'h000;
  localparam logic [8:0] SMX_SEL_MASK = 9'h0bf;
  localparam logic [8:0] SMX_VOL_MASK = 9'h1ff;
  localparam logic [8:0] SMX_ATT_MASK = 9'h0f0;
  localparam logic [8:0] SMX_EN_MASK  = 9'h003;

  // ----------------------------------------------------------------
  // Bypass gain, Q12: -15 dB to +6 dB in 3 dB steps
  // ----------------------------------------------------------------
  localparam logic [13:0] SMX_PIN_GAIN_Q12 [8] = '{
    14'h02d8, 14'h0405, 14'h05ad, 14'h0805,
    14'h0b54, 14'h1000, 14'h169a, 14'h1fed};
  localparam int unsigned SMX_GAIN_FRAC = 12;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0][8:0] sel;
    logic [1:0][8:0] vol;
    logic [8:0]      dac_att;
    logic [8:0]      mix_en;
    logic [1:0]      clip;
    logic            ack;
    logic [31:0]     rdat;
  } smx_regs_s;

  typedef struct packed {
    logic signed [15:0] mix;
    logic signed [15:0] stage;
    logic               vld;
    logic               clip;
  } smx_chan_s;

endpackage

/* File: design/smx_pin_gain.sv */
// Bypass pin gain: scales a sample by the selected 3 dB step.
// Assumes signed 16-bit samples; purely combinational.
`timescale 1ns/1ps
module smx_pin_gain
  import smx_pkg::*;
(
  // Control
  input  wire logic        [2:0]  code_i,
  // Samples
  input  wire logic signed [15:0] smp_i,
  output logic signed      [18:0] smp_o
);

  logic signed [30:0] prod;

  always_comb begin
    prod  = smp_i * $signed({1'b0, SMX_PIN_GAIN_Q12[code_i]});
    smp_o = prod[30:SMX_GAIN_FRAC];
  end

endmodule

/* File: design/smx_mix_chan.sv */
// One speaker mixer: sums enabled sources, mutes, powers, picks stage source.
// Assumes register fields come straight from the register file, same clock.
`timescale 1ns/1ps
module smx_mix_chan
  import smx_pkg::*;
(
  // System
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Sample strobe
  input  wire logic               vld_i,
  // Sources
  input  wire logic signed [15:0] ldac_i,
  input  wire logic signed [15:0] rdac_i,
  input  wire logic signed [15:0] lmix_i,
  input  wire logic signed [15:0] rmix_i,
  input  wire logic signed [15:0] lpin_i,
  input  wire logic signed [15:0] rpin_i,
  input  wire logic signed [15:0] direct_i,
  // Control
  input  wire logic        [8:0]  sel_i,
  input  wire logic        [8:0]  vol_i,
  input  wire logic        [1:0]  dac_att_i,
  input  wire logic               power_en_i,
  // Results
  output logic signed      [15:0] mix_o,
  output logic signed      [15:0] stage_o,
  output logic                    vld_o,
  output logic                    clip_o
);

  smx_chan_s          s_q;
  smx_chan_s          s_d;
  logic signed [18:0] lpin_g;
  logic signed [18:0] rpin_g;
  logic signed [19:0] sum;
  logic signed [15:0] sat;
  logic               ovf;
  logic               live;

  // ----------------------------------------------------------------
  // Source terms
  // ----------------------------------------------------------------
  function automatic logic signed [19:0] term(input logic en, input logic att,
                                              input logic signed [15:0] x);
    logic signed [19:0] v;
    v = {{4{x[15]}}, x};
    if (att) begin
      v = v >>> 1;
    end
    return en ? v : '0;
  endfunction

  smx_pin_gain u_lpin (
    .code_i (vol_i[SMX_VOL_LPIN_LSB +: 3]),
    .smp_i  (lpin_i),
    .smp_o  (lpin_g)
  );

  smx_pin_gain u_rpin (
    .code_i (vol_i[SMX_VOL_RPIN_LSB +: 3]),
    .smp_i  (rpin_i),
    .smp_o  (rpin_g)
  );

  // ----------------------------------------------------------------
  // Mix and saturate
  // ----------------------------------------------------------------
  always_comb begin
    sum = term(sel_i[SMX_SEL_LDAC_BIT], dac_att_i[1], ldac_i)
        + term(sel_i[SMX_SEL_RDAC_BIT], dac_att_i[0], rdac_i)
        + term(sel_i[SMX_SEL_LMIX_BIT], vol_i[SMX_VOL_LMIX_BIT], lmix_i)
        + term(sel_i[SMX_SEL_RMIX_BIT], vol_i[SMX_VOL_RMIX_BIT], rmix_i)
        + (sel_i[SMX_SEL_LPIN_BIT] ? {lpin_g[18], lpin_g} : 20'sh0_0000)
        + (sel_i[SMX_SEL_RPIN_BIT] ? {rpin_g[18], rpin_g} : 20'sh0_0000);
    ovf = (sum > 20'sh0_7fff) || (sum < -20'sh0_8000);
    if (sum > 20'sh0_7fff) begin
      sat = 16'sh7fff;
    end else if (sum < -20'sh0_8000) begin
      sat = -16'sh8000;
    end else begin
      sat = sum[15:0];
    end
    // Unpowered or muted mixer contributes silence
    live = power_en_i & ~vol_i[SMX_VOL_MUTE_BIT];
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  always_comb begin
    s_d      = s_q;
    s_d.vld  = vld_i;
    s_d.clip = 1'b0;
    if (vld_i) begin
      s_d.mix   = live ? sat : '0;
      s_d.stage = sel_i[SMX_SEL_SRC_BIT] ? (live ? sat : 16'sh0000) : direct_i;
      s_d.clip  = live & ovf;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign mix_o   = s_q.mix;
  assign stage_o = s_q.stage;
  assign vld_o   = s_q.vld;
  assign clip_o  = s_q.clip;

endmodule

/* File: verif/smx_speaker_mixer_top_properties.sv */
// Port-level checker for the speaker mixer control top.
// Assumes single clock, synchronous active-high reset; bound below.
`timescale 1ns/1ps
module smx_props
  import smx_pkg::*;
(
  // System
  input wire logic               clk_i,
  input wire logic               rst_i,
  // Wishbone
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_we_i,
  input wire logic        [9:0]  wb_adr_i,
  input wire logic        [3:0]  wb_sel_i,
  input wire logic        [31:0] wb_dat_i,
  input wire logic        [31:0] wb_dat_o,
  input wire logic               wb_ack_o,
  // Audio
  input wire logic               sample_valid_i,
  input wire logic signed [15:0] left_converter_out_i,
  input wire logic signed [15:0] left_out_mixer_o,
  input wire logic signed [15:0] left_gain_stage_o,
  input wire logic               sample_valid_o,
  input wire logic               left_out_mixer_power_en_o,
  input wire logic               right_out_mixer_power_en_o,
  input wire logic               left_gain_stage_source_sel_o
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wr_take;
  assign wr_take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:9] == 23'h0)
    else $error("read data above bit 8 not zero");
  a_power_write: assert property (wr_take && wb_adr_i[9:2] == SMX_IDX_MIX_EN |=>
    {left_out_mixer_power_en_o, right_out_mixer_power_en_o} == $past(wb_dat_i[1:0]))
    else $error("power enables do not follow write");
  a_srcsel_write: assert property (wr_take && wb_adr_i[9:2] == SMX_IDX_SEL_L |=>
    left_gain_stage_source_sel_o == $past(wb_dat_i[7]))
    else $error("stage source select does not follow write");
  a_valid_follow: assert property (sample_valid_i |=> sample_valid_o)
    else $error("output strobe missing");
  a_idle_hold: assert property (!sample_valid_i |=>
    !sample_valid_o && $stable(left_out_mixer_o) && $stable(left_gain_stage_o))
    else $error("outputs moved without a sample");
  a_unpowered_zero: assert property (sample_valid_i && !left_out_mixer_power_en_o |=>
    left_out_mixer_o == 16'sh0)
    else $error("unpowered mixer output not zero");
  a_stage_direct: assert property (sample_valid_i && !left_gain_stage_source_sel_o |=>
    left_gain_stage_o == $past(left_converter_out_i))
    else $error("stage not fed by converter");
  a_stage_mixer: assert property (sample_valid_i && left_gain_stage_source_sel_o |=>
    left_gain_stage_o == left_out_mixer_o)
    else $error("stage not fed by mixer");
endmodule
bind smx_speaker_mixer_top smx_props i_props (.*);

/* File: verif/smx_speaker_mixer_top_tb.sv */
// Self-checking bench for the speaker mixer control top.
// Assumes Wishbone replies in one cycle and outputs follow a sample by one.
`timescale 1ns/1ps
module smx_speaker_mixer_top_tb;
  import smx_pkg::*;
  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  logic               clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        [9:0]  wb_adr_i;
  logic        [3:0]  wb_sel_i;
  logic        [31:0] wb_dat_i, wb_dat_o, rdat;
  logic               sample_valid_i, sample_valid_o;
  logic               left_out_mixer_power_en_o, right_out_mixer_power_en_o;
  logic               left_gain_stage_source_sel_o, right_gain_stage_source_sel_o;
  logic signed [15:0] sp [6];
  logic signed [15:0] left_converter_out_i, right_converter_out_i, left_input_mixer_i;
  logic signed [15:0] right_input_mixer_i, left_bypass_pin_i, right_bypass_pin_i;
  logic signed [15:0] left_out_mixer_o, right_out_mixer_o, left_gain_stage_o, right_gain_stage_o;
  int                 mismatches, checks;
  int                 src [6];
  int                 rg [8];
  int                 e [4];
  int                 clp;
  // Index 6 is unmapped, 7 is the status word
  int ix [8]   = '{8'h63, 8'h69, 8'h6a, 8'h6b, 8'h6c, 8'h6d, 8'h70, 8'h7f};
  int msk [8]  = '{9'h003, 9'h0bf, 9'h0bf, 9'h1ff, 9'h1ff, 9'h0f0, 9'h000, 9'h000};
  int rstv [8] = '{9'h000, 9'h000, 9'h000, 9'h13f, 9'h13f, 9'h000, 9'h000, 9'h000};
  int gtab [8] = '{728, 1029, 1453, 2053, 2900, 4096, 5786, 8173};
  assign left_converter_out_i  = sp[0];
  assign right_converter_out_i = sp[1];
  assign left_input_mixer_i    = sp[2];
  assign right_input_mixer_i   = sp[3];
  assign left_bypass_pin_i     = sp[4];
  assign right_bypass_pin_i    = sp[5];
  smx_speaker_mixer_top i_dut (.*);
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk_reg(input string n, input int ex, input logic [31:0] got);
    checks++;
    if (got !== 32'(ex)) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", n, ex, got);
    end
  endtask
  task automatic chk_aud(input string n, input int ex, input logic [15:0] got);
    checks++;
    if (got !== 16'(ex)) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", n, 16'(ex), got);
    end
  endtask
  // Classic single cycle; waits for ack under a bound
  task automatic wb(input logic w, input int i, input int d, input logic [3:0] s);
    int n;
    int lm;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= {ix[i][7:0], 2'b00};
    wb_sel_i <= s;
    wb_dat_i <= 32'(d);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      conclude();
    end
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    lm = 32'({s[1], {8{s[0]}}});
    if (w) rg[i] = (rg[i] & ~lm) | (d & msk[i] & lm);
  endtask
  function automatic int mixv(input int m);
    int sl, v, s;
    sl = rg[1+m];
    v = rg[3+m];
    s = 0;
    if (sl[5]) s += src[0] >>> rg[5][7-2*m];
    if (sl[4]) s += src[1] >>> rg[5][6-2*m];
    if (sl[3]) s += src[2] >>> v[7];
    if (sl[2]) s += src[3] >>> v[6];
    if (sl[1]) s += (src[4] * gtab[v[5:3]]) >>> 12;
    if (sl[0]) s += (src[5] * gtab[v[2:0]]) >>> 12;
    if (!rg[0][1-m] || v[8]) return 0;
    // Sticky clip: bit 1 left, bit 0 right
    if (s > 32767 || s < -32768) clp[1-m] = 1'b1;
    return s > 32767 ? 32767 : (s < -32768 ? -32768 : s);
  endfunction
  // Back-to-back samples; each result checked the cycle after its strobe
  task automatic samp(input int n);
    for (int k = 0; k <= n; k++) begin
      @(posedge clk_i);
      sample_valid_i <= (k < n);
      for (int j = 0; j < 6; j++) src[j] = int'($urandom_range(65535)) - 32768;
      for (int j = 0; j < 6; j++) sp[j] <= 16'(src[j]);
      #1;
      if (k == 0) chk_reg("power", rg[0], {left_out_mixer_power_en_o, right_out_mixer_power_en_o});
      if (k == 0) chk_reg("srcsel", rg[1][7] * 2 + rg[2][7],
                          {left_gain_stage_source_sel_o, right_gain_stage_source_sel_o});
      if (k > 0) begin
        chk_aud("left mix", e[0], left_out_mixer_o);
        chk_aud("right mix", e[1], right_out_mixer_o);
        chk_aud("left stage", e[2], left_gain_stage_o);
        chk_aud("right stage", e[3], right_gain_stage_o);
        chk_reg("strobe", 1, 32'(sample_valid_o));
      end
      // Only a strobed sample may update the model or its clip flags
      if (k < n) begin
        e[0] = mixv(0);
        e[1] = mixv(1);
        e[2] = rg[1][7] ? e[0] : src[0];
        e[3] = rg[2][7] ? e[1] : src[1];
      end
    end
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, sample_valid_i} = 5'h1f & 5'h10;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    sp = '{default: 16'sh0};
    mismatches = 0;
    checks = 0;
    rg = rstv;
    clp = 0;
    void'($urandom(32'h689d_c981));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      wb(1'b0, i, 0, 4'h3);
      chk_reg("reset value", rg[i], rdat);
    end
    for (int i = 0; i < 7; i++) begin
      wb(1'b1, i, 9'h1ff, 4'h3);
      wb(1'b0, i, 0, 4'h3);
      chk_reg("all ones", rg[i], rdat);
    end
    wb(1'b1, 3, 0, 4'h1);
    wb(1'b0, 3, 0, 4'h3);
    chk_reg("lane write", rg[3], rdat);
    for (int t = 0; t < 40; t++) begin
      for (int i = 0; i < 6; i++) wb(1'b1, i, int'($urandom_range(511)), 4'h3);
      wb(1'b0, t % 7, 0, 4'h3);
      chk_reg("readback", rg[t % 7], rdat);
      samp(1 + t % 3);
      wb(1'b0, 7, 0, 4'h3);
      chk_reg("status", {rg[0][1] & ~rg[3][8], rg[0][0] & ~rg[4][8]} * 4 + clp, rdat);
      // Write one to clear both clip flags
      wb(1'b1, 7, 3, 4'h1);
      clp = 0;
    end
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rg = rstv;
    clp = 0;
    for (int i = 0; i < 8; i++) begin
      wb(1'b0, i, 0, 4'h3);
      chk_reg("second reset", rg[i], rdat);
    end
    samp(2);
    conclude();
  end
endmodule
